// >>> pmu_power_manager.sv
// power manager: inactivity timers, state stepping, smi, suspend request
// assumes activity inputs come from pins; core acknowledges suspend
// Function
// - doze, stand-by and suspend timers
// - timer expiry raises smi
// - system activity in power-down raises smi
// - on, doze, stand-by, suspend states
// - house-keeping activity kept in low state
// - peripheral timer flags peripheral idleness
// - suspend request modulation outside suspend, forced in suspend
// - plane power control outputs
// - internal clocks stopped in suspend
`timescale 1ns/1ps
module pmu_power_manager
   import pmu_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire pmu_act_t         act_pin,
   input  wire logic             cpu_cpu_suspend_request_n_ack,
   input  wire logic [THR_W-1:0] throttle,
   output pmu_smi_t             smi_src,
   output logic                 smi,
   output pmu_state_t           state,
   output logic                 cpu_suspend_request_n,
   output logic                 clk_stop,
   output logic [PLANE_W-1:0]   plane_en
);

   pmu_act_t   act_s1_q, act_s2_q;
   logic       ack_s1_q, ack_s2_q;
   pmu_state_t st_q;
   logic       doze_exp, stby_exp, cpu_suspend_request_n_exp, hk_exp, peri_exp;
   logic       hk_busy_q, cpu_suspend_request_n_req_q;
   logic [THR_W-1:0] thr_cnt_q;
   pmu_smi_t   smi_q;
   logic [PLANE_W-1:0] plane_q;

   // pin synchronisers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         act_s1_q <= '0;
         act_s2_q <= '0;
         ack_s1_q <= 1'b0;
         ack_s2_q <= 1'b0;
      end else begin
         act_s1_q <= act_pin;
         act_s2_q <= act_s1_q;
         ack_s1_q <= cpu_cpu_suspend_request_n_ack;
         ack_s2_q <= ack_s1_q;
      end
   end

   // inactivity timers
   pmu_timer u_doze (.clk(clk), .rst(rst), .en(1'b1), .reload(act_s2_q.sys),
      .start(TMR_W'(DOZE_CYC)), .expired(doze_exp));
   pmu_timer u_stby (.clk(clk), .rst(rst), .en(st_q != PM_ON),
      .reload(act_s2_q.sys), .start(TMR_W'(STBY_CYC)), .expired(stby_exp));
   pmu_timer u_cpu_suspend_request_n (.clk(clk), .rst(rst),
      .en(st_q == PM_STBY || st_q == PM_CPU_SUSPEND_REQUEST_N),
      .reload(act_s2_q.sys), .start(TMR_W'(CPU_SUSPEND_REQUEST_N_CYC)), .expired(cpu_suspend_request_n_exp));
   pmu_timer u_hk (.clk(clk), .rst(rst), .en(hk_busy_q), .reload(act_s2_q.hk),
      .start(TMR_W'(HK_CYC)), .expired(hk_exp));
   pmu_timer u_peri (.clk(clk), .rst(rst), .en(1'b1), .reload(act_s2_q.peri),
      .start(TMR_W'(PERI_CYC)), .expired(peri_exp));

   // house-keeping window: serviced without leaving the low state
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hk_busy_q <= 1'b0;
      end else if (act_s2_q.hk && (st_q == PM_DOZE || st_q == PM_STBY)) begin
         hk_busy_q <= 1'b1;
      end else if (hk_exp) begin
         hk_busy_q <= 1'b0;
      end
   end

   // power state stepping
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= PM_ON;
      end else if (act_s2_q.sys) begin
         st_q <= PM_ON;
      end else begin
         unique case (st_q)
            PM_ON:   if (doze_exp) st_q <= PM_DOZE;
            PM_DOZE: if (stby_exp) st_q <= PM_STBY;
            PM_STBY: if (cpu_suspend_request_n_exp) st_q <= PM_CPU_SUSPEND_REQUEST_N;
            PM_CPU_SUSPEND_REQUEST_N: st_q <= PM_CPU_SUSPEND_REQUEST_N;
            default: st_q <= PM_ON;
         endcase
      end
   end

   // smi sources: expiry and wake, registered as one-cycle pulses
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         smi_q <= '0;
      end else begin
         smi_q.doze_exp  <= doze_exp;
         smi_q.stby_exp  <= stby_exp;
         smi_q.cpu_suspend_request_n_exp  <= cpu_suspend_request_n_exp;
         smi_q.wake      <= act_s2_q.sys && (st_q != PM_ON);
         smi_q.peri_idle <= peri_exp;
      end
   end

   // suspend request: forced in suspend, duty-modulated otherwise
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         thr_cnt_q  <= '0;
         cpu_suspend_request_n_req_q <= 1'b0;
      end else begin
         thr_cnt_q  <= thr_cnt_q + THR_W'(1);
         cpu_suspend_request_n_req_q <= (st_q == PM_CPU_SUSPEND_REQUEST_N) || (thr_cnt_q < throttle);
      end
   end

   // plane control per state
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         plane_q <= PLANES_ON;
      end else begin
         unique case (st_q)
            PM_CPU_SUSPEND_REQUEST_N: plane_q <= PLANES_CPU_SUSPEND_REQUEST_N;
            PM_STBY: plane_q <= PLANES_STBY;
            default: plane_q <= PLANES_ON;
         endcase
      end
   end

   assign smi_src               = smi_q;
   assign smi                   = |smi_q;
   assign state                 = st_q;
   assign cpu_suspend_request_n = !cpu_suspend_request_n_req_q;
   // clocks stop only once the core has drained and acknowledged
   assign clk_stop              = (st_q == PM_CPU_SUSPEND_REQUEST_N) && ack_s2_q;
   assign plane_en              = plane_q;

   property p_wake;
      @(posedge clk) disable iff (rst)
      (act_s2_q.sys && st_q != PM_ON) |=> (smi_q.wake && st_q == PM_ON);
   endproperty
   a_wake: assert property (p_wake) else $error("wake smi missing");

   property p_doze;
      @(posedge clk) disable iff (rst)
      (doze_exp) |=> smi_q.doze_exp;
   endproperty
   a_doze: assert property (p_doze) else $error("doze smi missing");

   property p_step;
      @(posedge clk) disable iff (rst)
      (st_q == PM_ON && doze_exp && !act_s2_q.sys) |=> st_q == PM_DOZE;
   endproperty
   a_step: assert property (p_step) else $error("doze entry missing");

   property p_seq;
      @(posedge clk) disable iff (rst)
      stby_exp |-> st_q == PM_DOZE;
   endproperty
   a_seq: assert property (p_seq) else $error("stand-by out of order");

   property p_seq_cpu_suspend_request_n;
      @(posedge clk) disable iff (rst)
      cpu_suspend_request_n_exp |-> st_q == PM_STBY;
   endproperty
   a_seq_cpu_suspend_request_n: assert property (p_seq_cpu_suspend_request_n) else $error("suspend out of order");

   property p_cpu_suspend_request_n_req;
      @(posedge clk) disable iff (rst)
      (st_q == PM_CPU_SUSPEND_REQUEST_N) |=> !cpu_suspend_request_n;
   endproperty
   a_cpu_suspend_request_n_req: assert property (p_cpu_suspend_request_n_req) else $error("suspend request high");

   property p_clk;
      @(posedge clk) disable iff (rst)
      clk_stop |-> (st_q == PM_CPU_SUSPEND_REQUEST_N && $past(ack_s1_q));
   endproperty
   a_clk: assert property (p_clk) else $error("clock stopped wrongly");

   property p_plane;
      @(posedge clk) disable iff (rst)
      (st_q == PM_CPU_SUSPEND_REQUEST_N) [*2] |-> plane_en == PLANES_CPU_SUSPEND_REQUEST_N;
   endproperty
   a_plane: assert property (p_plane) else $error("plane not off");

   property p_reload;
      @(posedge clk) disable iff (rst)
      act_s2_q.sys |=> !doze_exp;
   endproperty
   a_reload: assert property (p_reload) else $error("timer not reloaded");

   // wake from suspend: clocks back first, planes powered one cycle later
   sequence s_cpu_suspend_request_n_wake;
      st_q == PM_CPU_SUSPEND_REQUEST_N && act_s2_q.sys;
   endsequence

   sequence s_resume;
      !clk_stop ##1 (plane_en == PLANES_ON);
   endsequence

   property p_resume;
      @(posedge clk) disable iff (rst)
      s_cpu_suspend_request_n_wake |=> s_resume;
   endproperty
   a_resume: assert property (p_resume) else $error("resume from suspend wrong");

   // gating follows the synchronised acknowledge while suspended
   sequence s_acked;
      st_q == PM_CPU_SUSPEND_REQUEST_N && ack_s2_q;
   endsequence

   property p_gate;
      @(posedge clk) disable iff (rst)
      s_acked |-> clk_stop;
   endproperty
   a_gate: assert property (p_gate) else $error("clocks not gated");

endmodule

// >>> pmu_pkg.sv
// package of the power manager: states, timer loads, carrier structs
// assumes a single 100 MHz clock domain
package pmu_pkg;

   localparam int unsigned CLK_MHZ      = 100;
   localparam int unsigned TMR_W        = 16;
   localparam int unsigned PLANE_W      = 4;
   localparam int unsigned THR_W        = 4;

   // timer start values in microseconds and derived clock counts
   localparam int unsigned DOZE_US      = 10;
   localparam int unsigned STBY_US      = 100;
   localparam int unsigned CPU_SUSPEND_REQUEST_N_US      = 400;
   localparam int unsigned HK_US        = 5;
   localparam int unsigned PERI_US      = 200;
   localparam int unsigned DOZE_CYC     = DOZE_US * CLK_MHZ;
   localparam int unsigned STBY_CYC     = STBY_US * CLK_MHZ;
   localparam int unsigned CPU_SUSPEND_REQUEST_N_CYC     = CPU_SUSPEND_REQUEST_N_US * CLK_MHZ;
   localparam int unsigned HK_CYC       = HK_US * CLK_MHZ;
   localparam int unsigned PERI_CYC     = PERI_US * CLK_MHZ;

   // power planes enabled per state
   localparam logic [3:0] PLANES_ON     = 4'hF;
   localparam logic [3:0] PLANES_STBY   = 4'h7;
   localparam logic [3:0] PLANES_CPU_SUSPEND_REQUEST_N   = 4'h1;

   typedef enum logic [3:0] {
      PM_ON   = 4'h1,
      PM_DOZE = 4'h2,
      PM_STBY = 4'h4,
      PM_CPU_SUSPEND_REQUEST_N = 4'h8
   } pmu_state_t;

   typedef struct packed {
      logic sys;
      logic hk;
      logic peri;
   } pmu_act_t;

   typedef struct packed {
      logic doze_exp;
      logic stby_exp;
      logic cpu_suspend_request_n_exp;
      logic wake;
      logic peri_idle;
   } pmu_smi_t;

endpackage

// >>> pmu_timer.sv
// down-counting inactivity timer with reload and one-cycle expiry pulse
// assumes reload and enable come from the same clock domain
`timescale 1ns/1ps
module pmu_timer
   import pmu_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             en,
   input  wire logic             reload,
   input  wire logic [TMR_W-1:0] start,
   output logic                  expired
);

   logic [TMR_W-1:0] cnt_q;
   logic             done_q;
   logic             armed_q;

   // first cycle after reset loads the start value, no false expiry
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q   <= '0;
         done_q  <= 1'b0;
         armed_q <= 1'b0;
      end else if (reload || !en || !armed_q) begin
         cnt_q   <= start;
         done_q  <= 1'b0;
         armed_q <= 1'b1;
      end else if (cnt_q != '0) begin
         cnt_q <= cnt_q - TMR_W'(1);
      end else begin
         done_q <= 1'b1;
      end
   end

   assign expired = en && armed_q && !reload && (cnt_q == '0) && !done_q;

endmodule

// >>> pmu_core_model.sv
// processor core seen from the power manager: drains, then acknowledges suspend
// assumes request is active low and synchronous to clk
`timescale 1ns/1ps
module pmu_core_model #(
   parameter int DRAIN = 8
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic cpu_suspend_request_n,
   output logic      cpu_cpu_suspend_request_n_ack
);
   int drain_cnt;

   // ack only after pending work drained; drops at once on release
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         drain_cnt    <= 0;
         cpu_cpu_suspend_request_n_ack <= 1'b0;
      end else if (cpu_suspend_request_n) begin
         drain_cnt    <= 0;
         cpu_cpu_suspend_request_n_ack <= 1'b0;
      end else if (drain_cnt < DRAIN) begin
         drain_cnt <= drain_cnt + 1;
      end else begin
         cpu_cpu_suspend_request_n_ack <= 1'b1;
      end
   end
endmodule

// >>> pmu_power_manager_tb.sv
// self-checking bench of the power manager
// assumes package timer loads and a core model on the suspend handshake
`timescale 1ns/1ps
module pmu_power_manager_tb;
   import pmu_pkg::*;
   logic             clk, rst, cpu_cpu_suspend_request_n_ack, smi, cpu_suspend_request_n, clk_stop;
   pmu_act_t         act_pin;
   logic [THR_W-1:0] throttle;
   pmu_smi_t         smi_src;
   pmu_state_t       state;
   logic [PLANE_W-1:0] plane_en;
   int               failures, total_checks, cycles, n, took, lows, w;
   int               smi_cnt[5];
   int               seed = 32'h488E0F46;
   bit               sys_h[$];
   pmu_state_t       st_h;

   pmu_power_manager dut (.clk(clk), .rst(rst), .act_pin(act_pin), .cpu_cpu_suspend_request_n_ack(cpu_cpu_suspend_request_n_ack),
      .throttle(throttle), .smi_src(smi_src), .smi(smi), .state(state),
      .cpu_suspend_request_n(cpu_suspend_request_n), .clk_stop(clk_stop), .plane_en(plane_en));
   pmu_core_model core (.clk(clk), .rst(rst), .cpu_suspend_request_n(cpu_suspend_request_n),
      .cpu_cpu_suspend_request_n_ack(cpu_cpu_suspend_request_n_ack));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic tick(int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   task automatic wait_for(logic [3:0] s, int max, output int t);
      t = 0;
      while (state !== s && t < max) begin
         tick(1);
         t++;
      end
   endtask

   task automatic sys_pulse();
      act_pin.sys = 1'b1;
      tick(1);
      act_pin.sys = 1'b0;
   endtask

   always @(posedge clk) begin
      for (int i = 0; i < 5; i++) if (smi_src[i] === 1'b1) smi_cnt[i]++;
      if (!rst && (smi === 1'b1 || |smi_src)) chk("smi", smi, |smi_src);
      if (!rst && sys_h.size() == 3) chk("wake", smi_src.wake, sys_h[0] && st_h != PM_ON);
      sys_h.push_back(act_pin.sys);
      if (sys_h.size() > 3) void'(sys_h.pop_front());
      st_h = state;
      cycles++;
      if (cycles == 90000) begin
         failures++;
         stop_test();
      end
   end

   initial begin
      act_pin  = '0;
      throttle = '0;
      rst      = 1'b1;
      repeat (16) @(posedge clk);
      #1 rst = 1'b0;
      chk("state", state, PM_ON);
      chk("planes", plane_en, PLANES_ON);
      chk("request", cpu_suspend_request_n, 1'b1);
      chk("clk_stop", clk_stop, 1'b0);
      $display("test reset done");
      act_pin.peri = 1'b1;
      tick(3);
      act_pin.peri = 1'b0;
      repeat (5) begin
         sys_pulse();
         n = DOZE_CYC / 2 + ($unsigned($random(seed)) % (DOZE_CYC / 4));
         tick(n);
         chk("state", state, PM_ON);
      end
      wait_for(PM_DOZE, DOZE_CYC, took);
      chk("doze time", (n + took >= DOZE_CYC - 2) && (n + took <= DOZE_CYC + 6), 1'b1);
      chk("state", state, PM_DOZE);
      tick(1);
      chk("doze smi", smi_cnt[4], 1);
      $display("test doze done");
      w = smi_cnt[1];
      act_pin.hk = 1'b1;
      tick(20);
      act_pin.hk = 1'b0;
      tick(10);
      chk("state", state, PM_DOZE);
      chk("wake smi", smi_cnt[1] - w, 0);
      sys_pulse();
      wait_for(PM_ON, 6, took);
      tick(1);
      chk("state", state, PM_ON);
      chk("wake smi", smi_cnt[1] - w, 1);
      $display("test wake done");
      wait_for(PM_DOZE, DOZE_CYC + 10, took);
      wait_for(PM_STBY, STBY_CYC + 10, took);
      chk("stby time", took >= STBY_CYC - 2 && took <= STBY_CYC + 4, 1'b1);
      tick(2);
      chk("planes", plane_en, PLANES_STBY);
      chk("stby smi", smi_cnt[3], 1);
      wait_for(PM_CPU_SUSPEND_REQUEST_N, CPU_SUSPEND_REQUEST_N_CYC + 10, took);
      chk("cpu_suspend_request_n time", took >= CPU_SUSPEND_REQUEST_N_CYC - 4 && took <= CPU_SUSPEND_REQUEST_N_CYC + 4, 1'b1);
      tick(2);
      chk("planes", plane_en, PLANES_CPU_SUSPEND_REQUEST_N);
      chk("request", cpu_suspend_request_n, 1'b0);
      tick(16);
      chk("clk_stop", clk_stop, 1'b1);
      chk("peri idle", smi_cnt[0] > 0, 1'b1);
      sys_pulse();
      wait_for(PM_ON, 6, took);
      tick(4);
      chk("state", state, PM_ON);
      chk("planes", plane_en, PLANES_ON);
      chk("clk_stop", clk_stop, 1'b0);
      $display("test suspend done");
      for (int k = 0; k < 4; k++) begin
         throttle = (k == 0) ? 4'h0 : (k == 1) ? 4'hF : (k == 2) ? 4'h8 : THR_W'($random(seed));
         tick(20);
         lows = 0;
         repeat (160) begin
            tick(1);
            lows += (cpu_suspend_request_n === 1'b0);
         end
         chk("throttle lows", lows, 10 * throttle);
      end
      throttle = '0;
      $display("test throttle done");
      stop_test();
   end
endmodule
